// [design/gssb_top.sv]
// Status string builder core: board state, register port and string readout.
`timescale 1ns/10ps
module gssb_top #(
	parameter int STR_LEN = gssb_pkg::STR_LEN
) (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [7:0]  address,
	input  wire logic [31:0] write_data,
	input  wire logic        write_strobe,
	input  wire logic        read_strobe,
	output logic      [31:0] read_data,
	input  wire logic        talk_addressed,
	input  wire logic        listen_addressed,
	input  wire logic        srq_line,
	input  wire logic        serial_poll_done,
	output logic             srq_drive
);
	////////////////////////////////////////////////////////////////////////////////
	logic       sync_talk_a, sync_talk;
	logic       sync_listen_a, sync_listen;
	logic       sync_srq_a, sync_srq;
	logic       sync_poll_a, sync_poll, poll_prev;
	logic       controller;
	logic [4:0] bus_address;
	logic       changed;
	logic       peripheral_request;
	logic       ctl_srq_pending;
	logic       ctl_srq_prev;
	gssb_pkg::gssb_role_e role;
	gssb_pkg::gssb_role_e next_role;
	logic       poll_pulse;
	logic       srq_rise;
	logic       wr_ctrl;
	logic       rd_str;
	logic       rd_str_first;
	logic [6:0] str_index;
	logic [7:0] str_char;
	logic [31:0] next_read_data;
	logic       role_change;
	logic       next_controller;
	logic [4:0] next_address;
	gssb_state_if st_if ();

	// Pins from the bus pass two flip-flops before use.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			{sync_talk_a, sync_talk, sync_listen_a, sync_listen} <= 4'h0;
			{sync_srq_a, sync_srq, sync_poll_a, sync_poll, poll_prev} <= 5'h00;
		end else begin
			sync_talk_a   <= talk_addressed;
			sync_talk     <= sync_talk_a;
			sync_listen_a <= listen_addressed;
			sync_listen   <= sync_listen_a;
			sync_srq_a    <= srq_line;
			sync_srq      <= sync_srq_a;
			sync_poll_a   <= serial_poll_done;
			sync_poll     <= sync_poll_a;
			poll_prev     <= sync_poll;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign poll_pulse = sync_poll && !poll_prev;
	assign srq_rise   = sync_srq && !ctl_srq_prev;
	assign wr_ctrl    = write_strobe && (address == gssb_pkg::REG_CTRL);
	assign rd_str     = read_strobe && (address >= gssb_pkg::REG_STR_BASE) &&
		(address < 8'(gssb_pkg::REG_STR_BASE + 8'(STR_LEN)));
	assign str_index  = 7'(address - gssb_pkg::REG_STR_BASE);
	// Reading the first character is taken as the start of a report.
	assign rd_str_first = rd_str && (address == gssb_pkg::REG_STR_BASE);
	assign next_role  = sync_talk ? gssb_pkg::ROLE_TALK :
		sync_listen ? gssb_pkg::ROLE_LISTEN : gssb_pkg::ROLE_IDLE;
	assign next_controller = wr_ctrl ? write_data[gssb_pkg::CTRL_CTL_BIT] : controller;
	// Addresses above the top of the range are held at the limit.
	assign next_address = (write_data[gssb_pkg::CTRL_ADR_LSB +: 5] > gssb_pkg::ADDR_MAX) ?
		gssb_pkg::ADDR_MAX : write_data[gssb_pkg::CTRL_ADR_LSB +: 5];
	assign role_change = (next_role != role) || (next_controller != controller);
	assign srq_drive   = !controller && peripheral_request;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			controller  <= 1'b0;
			bus_address <= gssb_pkg::ADDR_RESET;
			role        <= gssb_pkg::ROLE_IDLE;
		end else begin
			controller <= next_controller;
			role       <= next_role;
			if (wr_ctrl) begin
				bus_address <= next_address;
			end
		end
	end

	// A change seen in the same cycle as the clearing read wins.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			changed <= 1'b0;
		end else if (role_change) begin
			changed <= 1'b1;
		end else if (rd_str_first) begin
			changed <= 1'b0;
		end
	end

	// The host request holds the line until a controller polls the board or the board itself becomes controller.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			peripheral_request <= 1'b0;
		end else if (wr_ctrl && write_data[gssb_pkg::CTRL_REQ_BIT]) begin
			peripheral_request <= 1'b1;
		end else if (poll_pulse || controller) begin
			peripheral_request <= 1'b0;
		end
	end

	// A poll clears the pending flag even while the line stays asserted; only a new
	// rising edge sets it again, so a second requester can go unreported.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ctl_srq_pending <= 1'b0;
			ctl_srq_prev    <= 1'b0;
		end else begin
			ctl_srq_prev <= sync_srq;
			if (srq_rise) begin
				ctl_srq_pending <= 1'b1;
			end else if (poll_pulse) begin
				ctl_srq_pending <= 1'b0;
			end else if (!sync_srq) begin
				ctl_srq_pending <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign st_if.controller = controller;
	assign st_if.address    = bus_address;
	assign st_if.changed    = changed;
	assign st_if.role       = role;
	assign st_if.srq_state  = controller ? ctl_srq_pending : peripheral_request;

	gssb_render u_render (
		.st       (st_if.render),
		.index    (str_index),
		.char_out (str_char)
	);

	// The string window spans the full reader length, padded with NUL.
	always_comb begin
		next_read_data = 32'h0000_0000;
		if (read_strobe) begin
			if (address == gssb_pkg::REG_CTRL) begin
				next_read_data = {19'h00000, bus_address, 6'h00, peripheral_request, controller};
			end else if (address == gssb_pkg::REG_STATE) begin
				next_read_data = {24'h000000, sync_srq, st_if.srq_state, changed, 3'h0,
					role};
			end else if (rd_str) begin
				next_read_data = {24'h000000, str_char};
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			read_data <= 32'h0000_0000;
		end else begin
			read_data <= next_read_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	AST_CHG_SET: assert property (@(posedge clock) disable iff (!reset_n)
		role_change |=> changed)
		else $error("Change flag not set after role change.");
	AST_CHG_CLR: assert property (@(posedge clock) disable iff (!reset_n)
		(rd_str_first && !role_change) |=> !changed)
		else $error("Change flag not cleared by read.");
	AST_MODE_CH: assert property (@(posedge clock) disable iff (!reset_n)
		(read_strobe && address == gssb_pkg::REG_STR_BASE) |=>
		read_data[7:0] == ($past(controller) ? gssb_pkg::CH_C : gssb_pkg::CH_P))
		else $error("Mode character wrong.");
	AST_ADDR_MAX: assert property (@(posedge clock) disable iff (!reset_n)
		bus_address <= gssb_pkg::ADDR_MAX)
		else $error("Bus address out of range.");
	AST_GAP: assert property (@(posedge clock) disable iff (!reset_n)
		(read_strobe && address == 8'(gssb_pkg::REG_STR_BASE + 8'h01)) |=>
		read_data[7:0] == gssb_pkg::CH_SPACE)
		else $error("Gap column not a space.");
	sequence s_req_set;
		!controller && wr_ctrl && write_data[gssb_pkg::CTRL_REQ_BIT];
	endsequence
	AST_REQ_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
		s_req_set ##1 (!poll_pulse && !controller) |-> srq_drive)
		else $error("Request not held.");
	AST_POLL_CLR: assert property (@(posedge clock) disable iff (!reset_n)
		(poll_pulse && !srq_rise) |=> !ctl_srq_pending)
		else $error("Poll did not clear pending request.");
	AST_CTL_SRQ: assert property (@(posedge clock) disable iff (!reset_n)
		(controller && srq_rise && !wr_ctrl) |=> st_if.srq_state)
		else $error("Controller request not seen.");
	AST_CTL_SRQ_LOW: assert property (@(posedge clock) disable iff (!reset_n)
		(controller && !sync_srq && !wr_ctrl) |=> !st_if.srq_state)
		else $error("Controller request shown without line.");
	AST_SRQ_CH: assert property (@(posedge clock) disable iff (!reset_n)
		(read_strobe && address == 8'(gssb_pkg::REG_STR_BASE + 8'h0b)) |=>
		read_data[7:0] == ($past(st_if.srq_state) ? gssb_pkg::CH_ONE : gssb_pkg::CH_ZERO))
		else $error("Service request character wrong.");

	////////////////////////////////////////////////////////////////////////////////
	// Each digit of the address field reads back the decimal value in force.
	sequence s_read_tens;
		read_strobe && (address == 8'(gssb_pkg::REG_STR_BASE + 8'(gssb_pkg::COL_ADDR - 1)));
	endsequence
	sequence s_read_units;
		read_strobe && (address == 8'(gssb_pkg::REG_STR_BASE + 8'(gssb_pkg::COL_ADDR)));
	endsequence
	AST_ADDR_TENS: assert property (@(posedge clock) disable iff (!reset_n)
		s_read_tens |=>
		read_data[7:0] == 8'(gssb_pkg::CH_ZERO + 8'($past(bus_address) / 5'd10)))
		else $error("Address tens digit wrong.");
	AST_ADDR_UNITS: assert property (@(posedge clock) disable iff (!reset_n)
		s_read_units |=>
		read_data[7:0] == 8'(gssb_pkg::CH_ZERO + 8'($past(bus_address) % 5'd10)))
		else $error("Address units digit wrong.");

	sequence s_read_chg;
		read_strobe && (address == 8'(gssb_pkg::REG_STR_BASE + 8'(gssb_pkg::COL_CHG)));
	endsequence
	AST_CHG_CH: assert property (@(posedge clock) disable iff (!reset_n)
		s_read_chg |=>
		read_data[7:0] == ($past(changed) ? gssb_pkg::CH_ONE : gssb_pkg::CH_ZERO))
		else $error("Change character wrong.");

	sequence s_read_role;
		read_strobe && (address == 8'(gssb_pkg::REG_STR_BASE + 8'(gssb_pkg::COL_ROLE - 1)));
	endsequence
	AST_ROLE_CH: assert property (@(posedge clock) disable iff (!reset_n)
		s_read_role |=>
		read_data[7:0] == (($past(role) == gssb_pkg::ROLE_TALK) ? gssb_pkg::CH_T :
		($past(role) == gssb_pkg::ROLE_LISTEN) ? gssb_pkg::CH_L : gssb_pkg::CH_I))
		else $error("Role character wrong.");

	// Talk wins when the bus logic reports both roles at once.
	AST_ROLE_TALK: assert property (@(posedge clock) disable iff (!reset_n)
		sync_talk |=> role == gssb_pkg::ROLE_TALK)
		else $error("Role not talker.");
	AST_ROLE_LISTEN: assert property (@(posedge clock) disable iff (!reset_n)
		(!sync_talk && sync_listen) |=> role == gssb_pkg::ROLE_LISTEN)
		else $error("Role not listener.");
	AST_ROLE_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
		(!sync_talk && !sync_listen) |=> role == gssb_pkg::ROLE_IDLE)
		else $error("Role not idle.");

	// Columns past the last field hold NUL so that the reader finds the end.
	sequence s_read_tail;
		rd_str && (address >= 8'(gssb_pkg::REG_STR_BASE + 8'(gssb_pkg::FIELD_LEN)));
	endsequence
	AST_NUL_TAIL: assert property (@(posedge clock) disable iff (!reset_n)
		s_read_tail |=> read_data == 32'h0000_0000)
		else $error("Tail column not NUL.");
	AST_RD_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
		!read_strobe |=> read_data == 32'h0000_0000)
		else $error("Read data not zero outside a read.");

	AST_REQ_POLL: assert property (@(posedge clock) disable iff (!reset_n)
		(poll_pulse && !wr_ctrl) |=> !peripheral_request)
		else $error("Poll did not clear peripheral request.");
	AST_REQ_CTL: assert property (@(posedge clock) disable iff (!reset_n)
		controller |-> !srq_drive)
		else $error("Controller drives its own request.");
endmodule

// [include/gssb_pkg.sv]
// Package of constants, types and column layout for the status string builder.
// Functional notes
// - Column one reports C or P mode.
// - Columns three-four hold address 00 to 30.
// - Columns six-seven show G1 after role change.
// - Reading the first string character clears the change flag.
// - Column nine shows T, L or I.
// - Columns eleven-twelve show S1 or S0.
// - Controller mode service request mirrors SRQ line; the code clears it on a serial poll while the line stays asserted.
// - Peripheral request holds until serial poll or controller mode clears.
// - Reader buffer holds 75 bytes.
// - Controller serial poll may clear reported request.
package gssb_pkg;
	localparam int         STR_LEN      = 75;
	localparam int         FIELD_LEN    = 12;
	localparam int         COL_MODE     = 1;
	localparam int         COL_ADDR     = 3;
	localparam int         COL_CHG      = 6;
	localparam int         COL_ROLE     = 9;
	localparam int         COL_SRQ      = 11;
	localparam logic [4:0] ADDR_MAX     = 5'h1e;
	localparam logic [4:0] ADDR_RESET   = 5'h00;
	localparam logic [7:0] CH_SPACE     = 8'h20;
	localparam logic [7:0] CH_NUL       = 8'h00;
	localparam logic [7:0] CH_ZERO      = 8'h30;
	localparam logic [7:0] CH_ONE       = 8'h31;
	localparam logic [7:0] CH_C         = 8'h43;
	localparam logic [7:0] CH_P         = 8'h50;
	localparam logic [7:0] CH_G         = 8'h47;
	localparam logic [7:0] CH_T         = 8'h54;
	localparam logic [7:0] CH_L         = 8'h4c;
	localparam logic [7:0] CH_I         = 8'h49;
	localparam logic [7:0] CH_S         = 8'h53;
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATE    = 8'h01;
	localparam logic [7:0] REG_STR_BASE = 8'h40;
	localparam int         CTRL_CTL_BIT = 0;
	localparam int         CTRL_REQ_BIT = 1;
	localparam int         CTRL_ADR_LSB = 8;
	typedef enum logic [1:0] {ROLE_IDLE, ROLE_TALK, ROLE_LISTEN} gssb_role_e;
endpackage

// [include/gssb_state_if.sv]
// Interface carrying the board state from the core to the string renderer.
`timescale 1ns/10ps
interface gssb_state_if;
	logic                   controller;
	logic [4:0]             address;
	logic                   changed;
	gssb_pkg::gssb_role_e   role;
	logic                   srq_state;
	modport core   (output controller, output address, output changed, output role,
		output srq_state);
	modport render (input controller, input address, input changed, input role,
		input srq_state);
endinterface

// [design/gssb_render.sv]
// Renders one character of the fixed-column status string.
`timescale 1ns/10ps
module gssb_render (
	gssb_state_if.render st,
	input  wire logic [6:0] index,
	output logic      [7:0] char_out
);
	logic [3:0] tens;
	logic [3:0] units;
	logic [7:0] role_ch;
	assign tens    = (st.address >= 5'd30) ? 4'h3 : (st.address >= 5'd20) ? 4'h2 :
		(st.address >= 5'd10) ? 4'h1 : 4'h0;
	// The product is formed at five bits so that thirty does not wrap.
	assign units   = 4'(st.address - (5'(tens) * 5'd10));
	assign role_ch = (st.role == gssb_pkg::ROLE_TALK) ? gssb_pkg::CH_T :
		(st.role == gssb_pkg::ROLE_LISTEN) ? gssb_pkg::CH_L : gssb_pkg::CH_I;
	always_comb begin
		char_out = gssb_pkg::CH_SPACE;
		if (index >= 7'(gssb_pkg::FIELD_LEN)) begin
			char_out = gssb_pkg::CH_NUL;
		end else if (index == 7'(gssb_pkg::COL_MODE - 1)) begin
			char_out = st.controller ? gssb_pkg::CH_C : gssb_pkg::CH_P;
		end else if (index == 7'(gssb_pkg::COL_ADDR - 1)) begin
			char_out = gssb_pkg::CH_ZERO + {4'h0, tens};
		end else if (index == 7'(gssb_pkg::COL_ADDR)) begin
			char_out = gssb_pkg::CH_ZERO + {4'h0, units};
		end else if (index == 7'(gssb_pkg::COL_CHG - 1)) begin
			char_out = gssb_pkg::CH_G;
		end else if (index == 7'(gssb_pkg::COL_CHG)) begin
			char_out = st.changed ? gssb_pkg::CH_ONE : gssb_pkg::CH_ZERO;
		end else if (index == 7'(gssb_pkg::COL_ROLE - 1)) begin
			char_out = role_ch;
		end else if (index == 7'(gssb_pkg::COL_SRQ - 1)) begin
			char_out = gssb_pkg::CH_S;
		end else if (index == 7'(gssb_pkg::COL_SRQ)) begin
			char_out = st.srq_state ? gssb_pkg::CH_ONE : gssb_pkg::CH_ZERO;
		end
	end
endmodule

// [dv/gssb_bus_model.sv]
// Bus-side model: addressing levels, other devices' SRQ and the serial poll.
`timescale 1ns/10ps
module gssb_bus_model (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic [1:0] role_cmd,
	input  wire logic       other_srq,
	input  wire logic       poll_cmd,
	input  wire logic       srq_drive,
	output logic            talk_addressed,
	output logic            listen_addressed,
	output logic            srq_line,
	output logic            serial_poll_done
);
	logic [2:0] poll_cnt;
	assign talk_addressed   = role_cmd[0];
	assign listen_addressed = role_cmd[1];
	// SRQ is wired-OR, so the board's own request shows on the line as well.
	assign srq_line = other_srq | srq_drive;
	// The poll level is held several cycles so the synchroniser cannot miss it.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			poll_cnt <= 3'h0;
		end else if (poll_cmd) begin
			poll_cnt <= 3'h6;
		end else if (poll_cnt != 3'h0) begin
			poll_cnt <= poll_cnt - 3'h1;
		end
	end
	assign serial_poll_done = poll_cnt != 3'h0;
endmodule

// [dv/gssb_top_tb_top.sv]
// Self-checking testbench of the status string builder.
`timescale 1ns/10ps
module gssb_top_tb_top;
	logic        clock;
	logic        reset_n;
	logic [7:0]  address;
	logic [31:0] write_data;
	logic        write_strobe;
	logic        read_strobe;
	logic [31:0] read_data;
	logic [1:0]  role_cmd;
	logic        other_srq;
	logic        poll_cmd;
	logic        talk_addressed;
	logic        listen_addressed;
	logic        srq_line;
	logic        serial_poll_done;
	logic        srq_drive;
	logic [31:0] rd_val;
	int          error_cnt;
	int          samples_checked;
	int          ea;
	int          gaps[4] = '{2, 5, 8, 10};
	logic [1:0]  rc[4]   = '{2'h1, 2'h2, 2'h3, 2'h0};
	logic [7:0]  rch[4]  = '{8'h54, 8'h4c, 8'h54, 8'h49};
	gssb_top uut (.clock(clock), .reset_n(reset_n), .address(address),
		.write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
		.read_data(read_data), .talk_addressed(talk_addressed),
		.listen_addressed(listen_addressed), .srq_line(srq_line),
		.serial_poll_done(serial_poll_done), .srq_drive(srq_drive));
	gssb_bus_model bus (.clock(clock), .reset_n(reset_n), .role_cmd(role_cmd),
		.other_srq(other_srq), .poll_cmd(poll_cmd), .srq_drive(srq_drive),
		.talk_addressed(talk_addressed), .listen_addressed(listen_addressed),
		.srq_line(srq_line), .serial_poll_done(serial_poll_done));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		address      <= a;
		write_data   <= d;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		address     <= a;
		read_strobe <= 1'b1;
		@(posedge clock);
		read_strobe <= 1'b0;
		// The answer stands until the next edge, so it is taken there.
		@(posedge clock);
		rd_val = read_data;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic col(input int c, input logic [7:0] e);
		rd(8'(8'h40 + c - 1));
		chk(rd_val, {24'h0, e});
	endtask
	task automatic poll();
		poll_cmd <= 1'b1;
		@(posedge clock);
		poll_cmd <= 1'b0;
		idle(10);
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// A hung design still reaches the verdict, counted as a mismatch.
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		complete_run();
	end
	initial begin
		reset_n = 1'b0;
		address = 8'h00;
		write_data = 32'h0;
		write_strobe = 1'b0;
		read_strobe = 1'b0;
		role_cmd = 2'h0;
		other_srq = 1'b0;
		poll_cmd = 1'b0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		foreach (gaps[i]) col(gaps[i], gssb_pkg::CH_SPACE);
		col(3, gssb_pkg::CH_ZERO);
		col(6, gssb_pkg::CH_G);
		col(7, gssb_pkg::CH_ZERO);
		col(9, gssb_pkg::CH_I);
		col(11, gssb_pkg::CH_S);
		col(12, gssb_pkg::CH_ZERO);
		col(75, gssb_pkg::CH_NUL);
		rd(8'h8b);
		chk(rd_val, 32'h0);
		col(1, gssb_pkg::CH_P);
		$display("Test reset state done");
		// Addresses above the limit are clamped, so 31 must read back as 30.
		for (int a = 0; a < 32; a++) begin
			wr(gssb_pkg::REG_CTRL, 32'(a) << 8);
			ea = (a > 30) ? 30 : a;
			col(3, 8'(gssb_pkg::CH_ZERO + ea / 10));
			col(4, 8'(gssb_pkg::CH_ZERO + ea % 10));
		end
		$display("Test address done");
		wr(gssb_pkg::REG_CTRL, 32'h1);
		col(7, gssb_pkg::CH_ONE);
		col(1, gssb_pkg::CH_C);
		col(7, gssb_pkg::CH_ZERO);
		$display("Test mode done");
		for (int i = 0; i < 4; i++) begin
			role_cmd <= rc[i];
			idle(5);
			col(9, rch[i]);
			col(7, gssb_pkg::CH_ONE);
			col(1, gssb_pkg::CH_C);
		end
		col(7, gssb_pkg::CH_ZERO);
		$display("Test roles done");
		other_srq <= 1'b1;
		idle(5);
		col(12, gssb_pkg::CH_ONE);
		other_srq <= 1'b0;
		idle(5);
		col(12, gssb_pkg::CH_ZERO);
		other_srq <= 1'b1;
		idle(5);
		poll();
		col(12, gssb_pkg::CH_ZERO);
		rd(gssb_pkg::REG_STATE);
		chk(rd_val, 32'h0000_0080);
		other_srq <= 1'b0;
		idle(5);
		col(12, gssb_pkg::CH_ZERO);
		$display("Test controller request done");
		wr(gssb_pkg::REG_CTRL, 32'h0);
		wr(gssb_pkg::REG_CTRL, 32'h2);
		col(12, gssb_pkg::CH_ONE);
		chk({31'h0, srq_drive}, 32'h1);
		rd(gssb_pkg::REG_CTRL);
		chk(rd_val, 32'h0000_0002);
		idle(20);
		col(12, gssb_pkg::CH_ONE);
		poll();
		col(12, gssb_pkg::CH_ZERO);
		chk({31'h0, srq_drive}, 32'h0);
		$display("Test peripheral request done");
		complete_run();
	end
endmodule
